/* vbus_monitor_pkg.sv */
// shared constants, register map and state types for the vbus monitor block
package vbus_monitor_pkg;

	// register offsets (byte addresses of 16-bit registers)
	localparam logic [7:0] ALERT_FLAGS_OFS      = 8'h10;
	localparam logic [7:0] POWER_CONFIG_OFS     = 8'h1c;
	localparam logic [7:0] STOP_THRESHOLD_OFS   = 8'h74;
	localparam logic [7:0] HIGH_ALARM_OFS       = 8'h76;
	localparam logic [7:0] LOW_ALARM_OFS        = 8'h78;
	localparam logic [7:0] CUR_MON_CFG_OFS      = 8'h90;
	localparam logic [7:0] CUR_READING_OFS      = 8'h92;
	localparam logic [7:0] PEAK_CURRENT_OFS     = 8'h94;
	localparam logic [7:0] MEAN_CURRENT_OFS     = 8'h96;
	localparam logic [7:0] ROLE_SWAP_CFG_OFS    = 8'h98;
	localparam logic [7:0] SINK_DIS_CFG_OFS     = 8'h9a;
	localparam logic [7:0] VENDOR_STATUS_OFS    = 8'ha0;

	// field positions
	localparam int HIGH_ALARM_FLAG_BIT  = 9;
	localparam int LOW_ALARM_FLAG_BIT   = 10;
	localparam int FORCE_DIS_BIT        = 2;
	localparam int AUTO_DIS_BIT         = 4;
	localparam int ALARM_DISABLE_BIT    = 5;
	localparam int FRS_ENABLE_BIT       = 7;
	localparam int CUR_MON_DISABLE_BIT  = 0;
	localparam int MEAN_DIV_LSB         = 1;
	localparam int PEAK_EN_BIT          = 4;
	localparam int MEAN_EXP_LSB         = 5;
	localparam int MEAN_EN_BIT          = 7;
	localparam int SWAP_TRIGGER_BIT     = 4;
	localparam int SINK_MODE_BIT        = 0;
	localparam int MANUAL_REQ_BIT       = 1;
	localparam int TIMEOUT_LSB          = 4;
	localparam int SINK_DONE_BIT        = 14;
	localparam int SINK_TIMEOUT_BIT     = 15;

	// reset values
	localparam logic [7:0]  POWER_CONFIG_RST   = 8'h20;
	localparam logic [7:0]  CUR_MON_CFG_RST    = 8'h00;
	localparam logic [7:0]  ROLE_SWAP_CFG_RST  = 8'h10;
	localparam logic [7:0]  SINK_DIS_CFG_RST   = 8'h01;
	localparam logic [15:0] HIGH_ALARM_RST     = 16'hffff;
	localparam logic [15:0] LOW_ALARM_RST      = 16'h0000;
	localparam logic [15:0] STOP_THRESHOLD_RST = 16'h0000;

	// voltage limits in millivolts
	localparam logic [15:0] VSAFE0V_MAX_MV = 16'h0320;
	localparam logic [15:0] VSAFE5V_MAX_MV = 16'h157c;

	// timing: one timeout step
	localparam int CLK_HZ           = 25_000_000;
	localparam int TIMEOUT_STEP_US  = 1000;
	localparam int TIMEOUT_STEP_CYC = CLK_HZ / 1_000_000 * TIMEOUT_STEP_US;

	typedef enum logic [1:0] {
		SNK_IDLE   = 2'b00,
		SNK_AUTO   = 2'b01,
		SNK_MANUAL = 2'b10
	} sink_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] vbus_mv;
		logic [15:0] sink_path_mv;
		logic [15:0] cur_sample;
		logic        cur_valid;
		logic        is_source;
		logic        disconnect;
		logic        sink_vbus_cmd;
	} meas_t;

endpackage

/* vbus_monitor_discharge_ctrl.sv */
// bus_current_reading/alarm monitor, vbus and sink-path discharge, sink fast role swap gates
`timescale 1ns/1ps
// Functional notes
// [RULE_01] current reading register updates with each sample while monitor not disabled
// [RULE_02] peak kept only if peak enable set; mean only if mean enable set
// [RULE_03] peak register holds the largest current sample seen while enabled
// [RULE_04] mean starts at zero; adds (sample minus mean) over factor times power of two
// [RULE_05] voltage alarms disabled at reset; manager enables by clearing disable bit
// [RULE_06] high flag set while vbus above high level, re-set after clear if persisting
// [RULE_07] low flag set while vbus below low level, re-set after clear unless disabled
// [RULE_08] auto discharge bit makes a disconnect start a vbus discharge
// [RULE_09] writing force discharge bit starts a vbus discharge
// [RULE_10] discharge ends once vbus falls below the safe zero level
// [RULE_11] ended discharge never restarts by itself, only on a new command or event
// [RULE_12] as source with force set, discharge ends below the stop threshold register
// [RULE_13] auto mode: sink command with high path bleeds it, then turns sink gate on
// [RULE_14] auto mode timeout sets status bits 14 and 15, alerts, drops the command
// [RULE_15] a disconnect never bleeds the internal sink path
// [RULE_16] manual mode: request bleeds path; below level sets bit 14 and alerts
// [RULE_17] manual mode timeout sets bits 14 and 15 and alerts
// [RULE_18] after manual completion the manager may enable the other port's sink
// [RULE_19] role swap signal turns sink gate off first, then source gate on
// [RULE_20] role swap gate settings act only while role swap enable is set
// [RULE_21] manager clears role swap enable before sending the swap message
// [RULE_22] only initial-sink role swap is handled
// [RULE_23] alarm flags clear on writing one; writing zero keeps them
module vbus_monitor_discharge_ctrl #(
	parameter int STEP_CYCLES = vbus_monitor_pkg::TIMEOUT_STEP_CYC
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_b,
	input  wire vbus_monitor_pkg::reg_req_t i_req,
	input  wire vbus_monitor_pkg::meas_t    i_meas,
	input  wire logic                       i_frs_signal,
	output logic [15:0]                     o_rdata,
	output logic                            o_alert_b,
	output logic                            o_vbus_discharge,
	output logic                            o_sink_path_bleed_pin,
	output logic                            o_sink_gate,
	output logic                            o_source_gate
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [15:0]                   rdata;
		logic                          alert_b;
		logic [15:0]                   alert_flags;
		logic [7:0]                    power_config;
		logic [15:0]                   stop_threshold;
		logic [15:0]                   high_level;
		logic [15:0]                   low_level;
		logic [7:0]                    cur_cfg;
		logic [15:0]                   cur_reading;
		logic [15:0]                   peak;
		logic [15:0]                   mean;
		logic [7:0]                    swap_cfg;
		logic [7:0]                    sink_cfg;
		logic [15:0]                   vendor_status;
		logic                          vbus_dis;
		logic                          force_run;
		vbus_monitor_pkg::sink_state_t snk_state;
		logic [15:0]                   step_cnt;
		logic [3:0]                    steps;
		logic                          bleed;
		logic                          sink_gate;
		logic                          source_gate;
		logic                          swap_wait;
		logic [3:0]                    swap_cnt;
		logic                          frs_meta;
		logic                          frs_sync;
		logic                          frs_prev;
	} state_t;

	state_t st_q;
	state_t st_d;

	localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [15:0] mean_step(
		input logic [15:0] mean,
		input logic [15:0] sample,
		input logic [2:0]  div_field,
		input logic [1:0]  exp_field
	);
		logic signed [17:0] diff;
		logic signed [17:0] quot;
		logic signed [17:0] divisor;
		diff = $signed({2'b00, sample}) - $signed({2'b00, mean});
		divisor = $signed({14'h0000, 4'({1'b0, div_field} + 4'h1)});
		quot = (diff / divisor) >>> exp_field;
		mean_step = 16'($signed({2'b00, mean}) + quot);
	endfunction

	function automatic logic [15:0] wmask(
		input logic [15:0] cur,
		input logic [15:0] wd,
		input int          width
	);
		wmask = (width == 8) ? {8'h00, wd[7:0]} : wd;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic        wr_hit;
	logic [15:0] rd_mux;
	logic        force_write;
	logic        manual_write;
	logic        alarms_on;
	logic        frs_edge;
	logic        step_done;
	logic        steps_done;

	always_comb
	begin
		st_d = st_q;
		force_write  = 1'b0;
		manual_write = 1'b0;
		wr_hit       = i_req.wr;
		alarms_on    = ~st_q.power_config[vbus_monitor_pkg::ALARM_DISABLE_BIT];
		frs_edge     = st_q.frs_sync & ~st_q.frs_prev;
		step_done    = (st_q.step_cnt == STEP_LAST);
		steps_done   = step_done && (st_q.steps == st_q.sink_cfg[7:vbus_monitor_pkg::TIMEOUT_LSB]);

		// pin synchroniser for the role swap signal
		st_d.frs_meta = i_frs_signal;
		st_d.frs_sync = st_q.frs_meta;
		st_d.frs_prev = st_q.frs_sync;

		// register writes
		if (wr_hit)
		begin
			case (i_req.addr)
				vbus_monitor_pkg::ALERT_FLAGS_OFS:
					st_d.alert_flags = st_q.alert_flags & ~i_req.wdata; // RULE_23
				vbus_monitor_pkg::POWER_CONFIG_OFS:
				begin
					st_d.power_config = i_req.wdata[7:0]; // RULE_05
					force_write = i_req.wdata[vbus_monitor_pkg::FORCE_DIS_BIT];
				end
				vbus_monitor_pkg::STOP_THRESHOLD_OFS:
					st_d.stop_threshold = i_req.wdata;
				vbus_monitor_pkg::HIGH_ALARM_OFS:
					st_d.high_level = i_req.wdata;
				vbus_monitor_pkg::LOW_ALARM_OFS:
					st_d.low_level = i_req.wdata;
				vbus_monitor_pkg::CUR_MON_CFG_OFS:
					st_d.cur_cfg = i_req.wdata[7:0];
				vbus_monitor_pkg::ROLE_SWAP_CFG_OFS:
					st_d.swap_cfg = i_req.wdata[7:0];
				vbus_monitor_pkg::SINK_DIS_CFG_OFS:
				begin
					// request bit is a command, it never stays stored
					st_d.sink_cfg = i_req.wdata[7:0];
					st_d.sink_cfg[vbus_monitor_pkg::MANUAL_REQ_BIT] = 1'b0;
					manual_write = i_req.wdata[vbus_monitor_pkg::MANUAL_REQ_BIT];
				end
				vbus_monitor_pkg::VENDOR_STATUS_OFS:
					st_d.vendor_status = st_q.vendor_status & ~i_req.wdata;
				default:
				begin
				end
			endcase
		end

		// read path, unmapped offsets read zero
		case (i_req.addr)
			vbus_monitor_pkg::ALERT_FLAGS_OFS:
				rd_mux = st_q.alert_flags;
			vbus_monitor_pkg::POWER_CONFIG_OFS:
				rd_mux = {8'h00, st_q.power_config};
			vbus_monitor_pkg::STOP_THRESHOLD_OFS:
				rd_mux = st_q.stop_threshold;
			vbus_monitor_pkg::HIGH_ALARM_OFS:
				rd_mux = st_q.high_level;
			vbus_monitor_pkg::LOW_ALARM_OFS:
				rd_mux = st_q.low_level;
			vbus_monitor_pkg::CUR_MON_CFG_OFS:
				rd_mux = {8'h00, st_q.cur_cfg};
			vbus_monitor_pkg::CUR_READING_OFS:
				rd_mux = st_q.cur_reading;
			vbus_monitor_pkg::PEAK_CURRENT_OFS:
				rd_mux = st_q.peak;
			vbus_monitor_pkg::MEAN_CURRENT_OFS:
				rd_mux = st_q.mean;
			vbus_monitor_pkg::ROLE_SWAP_CFG_OFS:
				rd_mux = {8'h00, st_q.swap_cfg};
			vbus_monitor_pkg::SINK_DIS_CFG_OFS:
				rd_mux = {8'h00, st_q.sink_cfg};
			vbus_monitor_pkg::VENDOR_STATUS_OFS:
				rd_mux = st_q.vendor_status;
			default:
				rd_mux = 16'h0000;
		endcase
		if (i_req.rd)
			st_d.rdata = rd_mux;

		////////////////////////////////////////////////////////////////////////
		// current monitor; peak only grows, only a reset lowers it
		if (i_meas.cur_valid)
		begin
			if (!st_q.cur_cfg[vbus_monitor_pkg::CUR_MON_DISABLE_BIT])
				st_d.cur_reading = i_meas.cur_sample; // RULE_01
			if (st_q.cur_cfg[vbus_monitor_pkg::PEAK_EN_BIT] && i_meas.cur_sample > st_q.peak)
				st_d.peak = i_meas.cur_sample; // RULE_02 RULE_03
			if (st_q.cur_cfg[vbus_monitor_pkg::MEAN_EN_BIT])
				st_d.mean = mean_step(st_q.mean, i_meas.cur_sample, // RULE_02
					st_q.cur_cfg[vbus_monitor_pkg::MEAN_DIV_LSB +: 3],
					st_q.cur_cfg[vbus_monitor_pkg::MEAN_EXP_LSB +: 2]); // RULE_04
		end
		// a disabled mean restarts from zero when enabled again
		if (!st_q.cur_cfg[vbus_monitor_pkg::MEAN_EN_BIT])
			st_d.mean = 16'h0000; // RULE_04

		////////////////////////////////////////////////////////////////////////
		// voltage alarms; hardware set wins over the clearing write
		if (alarms_on && i_meas.vbus_mv > st_q.high_level)
			st_d.alert_flags[vbus_monitor_pkg::HIGH_ALARM_FLAG_BIT] = 1'b1; // RULE_06
		if (alarms_on && i_meas.vbus_mv < st_q.low_level)
			st_d.alert_flags[vbus_monitor_pkg::LOW_ALARM_FLAG_BIT] = 1'b1; // RULE_07

		////////////////////////////////////////////////////////////////////////
		// vbus discharge
		if (st_q.vbus_dis)
		begin
			if (st_q.force_run && i_meas.is_source)
			begin
				if (i_meas.vbus_mv < st_q.stop_threshold)
					st_d.vbus_dis = 1'b0; // RULE_12
			end
			else if (i_meas.vbus_mv < vbus_monitor_pkg::VSAFE0V_MAX_MV)
				st_d.vbus_dis = 1'b0; // RULE_10 RULE_11
		end
		if (i_meas.disconnect && st_q.power_config[vbus_monitor_pkg::AUTO_DIS_BIT])
		begin
			st_d.vbus_dis  = 1'b1; // RULE_08
			st_d.force_run = 1'b0;
		end
		// a force write beats a same-cycle disconnect and keeps the source stop level
		if (force_write)
		begin
			st_d.vbus_dis  = 1'b1; // RULE_09
			st_d.force_run = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////
		// sink path discharge; disconnect opens the gate but never bleeds
		if (i_meas.disconnect)
			st_d.sink_gate = 1'b0; // RULE_15
		// one shared step counter; a new bleed restarts it so the timeout runs from the request
		st_d.step_cnt = step_done ? 16'h0000 : 16'(st_q.step_cnt + 16'h0001);
		if (step_done)
			st_d.steps = 4'(st_q.steps + 4'h1);
		case (st_q.snk_state)
			vbus_monitor_pkg::SNK_IDLE:
			begin
				st_d.bleed = 1'b0;
				if (i_meas.sink_vbus_cmd && st_q.sink_cfg[vbus_monitor_pkg::SINK_MODE_BIT])
				begin
					if (i_meas.sink_path_mv > vbus_monitor_pkg::VSAFE5V_MAX_MV)
						st_d.snk_state = vbus_monitor_pkg::SNK_AUTO; // RULE_13
					else
						st_d.sink_gate = 1'b1; // RULE_13
				end
				else if (i_meas.sink_vbus_cmd)
					st_d.sink_gate = 1'b1;
				else if (manual_write && !st_q.sink_cfg[vbus_monitor_pkg::SINK_MODE_BIT])
					st_d.snk_state = vbus_monitor_pkg::SNK_MANUAL; // RULE_16
				if (st_d.snk_state != vbus_monitor_pkg::SNK_IDLE)
				begin
					st_d.bleed    = 1'b1;
					st_d.step_cnt = 16'h0000;
					st_d.steps    = 4'h0;
				end
			end
			vbus_monitor_pkg::SNK_AUTO:
			begin
				if (i_meas.sink_path_mv < vbus_monitor_pkg::VSAFE5V_MAX_MV)
				begin
					st_d.bleed     = 1'b0; // RULE_13
					st_d.sink_gate = 1'b1;
					st_d.snk_state = vbus_monitor_pkg::SNK_IDLE;
				end
				else if (steps_done)
				begin
					// command dropped: gate stays as it was
					st_d.bleed = 1'b0; // RULE_14
					st_d.vendor_status[vbus_monitor_pkg::SINK_DONE_BIT]    = 1'b1;
					st_d.vendor_status[vbus_monitor_pkg::SINK_TIMEOUT_BIT] = 1'b1;
					st_d.snk_state = vbus_monitor_pkg::SNK_IDLE;
				end
			end
			vbus_monitor_pkg::SNK_MANUAL:
			begin
				if (i_meas.sink_path_mv < vbus_monitor_pkg::VSAFE5V_MAX_MV)
				begin
					st_d.bleed = 1'b0; // RULE_16
					st_d.vendor_status[vbus_monitor_pkg::SINK_DONE_BIT] = 1'b1;
					st_d.snk_state = vbus_monitor_pkg::SNK_IDLE;
				end
				else if (steps_done)
				begin
					st_d.bleed = 1'b0; // RULE_17
					st_d.vendor_status[vbus_monitor_pkg::SINK_DONE_BIT]    = 1'b1;
					st_d.vendor_status[vbus_monitor_pkg::SINK_TIMEOUT_BIT] = 1'b1;
					st_d.snk_state = vbus_monitor_pkg::SNK_IDLE;
				end
			end
			default:
			begin
				st_d.bleed     = 1'b0;
				st_d.snk_state = vbus_monitor_pkg::SNK_IDLE;
			end
		endcase

		////////////////////////////////////////////////////////////////////////
		// initial-sink fast role swap: sink gate off, wait, source gate on
		if (st_q.power_config[vbus_monitor_pkg::FRS_ENABLE_BIT]) // RULE_20
		begin
			if (frs_edge && st_q.swap_cfg[vbus_monitor_pkg::SWAP_TRIGGER_BIT]
				&& st_q.sink_gate)
			begin
				st_d.sink_gate = 1'b0; // RULE_19 RULE_22
				st_d.swap_wait = 1'b1;
				st_d.swap_cnt  = st_q.swap_cfg[3:0];
			end
			else if (st_q.swap_wait)
			begin
				if (st_q.swap_cnt == 4'h0)
				begin
					st_d.source_gate = 1'b1; // RULE_19
					st_d.swap_wait   = 1'b0;
				end
				else
					st_d.swap_cnt = 4'(st_q.swap_cnt - 4'h1);
			end
		end
		else
			st_d.swap_wait = 1'b0; // RULE_20

		// alert pin low while any flag awaits service
		st_d.alert_b = ~((|st_d.alert_flags) | (|st_d.vendor_status)); // RULE_14 RULE_16
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_q                <= '0;
			st_q.alert_b        <= 1'b1;
			st_q.power_config   <= vbus_monitor_pkg::POWER_CONFIG_RST; // RULE_05
			st_q.stop_threshold <= vbus_monitor_pkg::STOP_THRESHOLD_RST;
			st_q.high_level     <= vbus_monitor_pkg::HIGH_ALARM_RST;
			st_q.low_level      <= vbus_monitor_pkg::LOW_ALARM_RST;
			st_q.cur_cfg        <= vbus_monitor_pkg::CUR_MON_CFG_RST;
			st_q.swap_cfg       <= vbus_monitor_pkg::ROLE_SWAP_CFG_RST;
			st_q.sink_cfg       <= vbus_monitor_pkg::SINK_DIS_CFG_RST;
			st_q.snk_state      <= vbus_monitor_pkg::SNK_IDLE;
		end
		else
			st_q <= st_d;
	end

	assign o_rdata               = st_q.rdata;
	assign o_alert_b             = st_q.alert_b;
	assign o_vbus_discharge      = st_q.vbus_dis;
	assign o_sink_path_bleed_pin = st_q.bleed;
	assign o_sink_gate           = st_q.sink_gate;
	assign o_source_gate         = st_q.source_gate;

endmodule

/* vbus_monitor_discharge_ctrl_properties.sv */
// port-level timing checks for the vbus monitor and discharge block
`timescale 1ns/1ps
module vbus_monitor_discharge_ctrl_checker #(
	parameter int STEP_CYCLES = vbus_monitor_pkg::TIMEOUT_STEP_CYC
) (
	input wire logic                       i_clk,
	input wire logic                       i_rst_b,
	input wire vbus_monitor_pkg::reg_req_t i_req,
	input wire vbus_monitor_pkg::meas_t    i_meas,
	input wire logic                       i_frs_signal,
	input wire logic [15:0]                o_rdata,
	input wire logic                       o_alert_b,
	input wire logic                       o_vbus_discharge,
	input wire logic                       o_sink_path_bleed_pin,
	input wire logic                       o_sink_gate,
	input wire logic                       o_source_gate
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	logic force_wr;
	logic bleed_req;
	logic gate_req;
	int   bleed_cnt_q;
	assign force_wr  = i_req.wr && i_req.addr == 8'h1c && i_req.wdata[2];
	assign bleed_req = i_meas.sink_vbus_cmd || (i_req.wr && i_req.addr == 8'h9a && i_req.wdata[1]);
	assign gate_req  = i_meas.sink_vbus_cmd || o_sink_path_bleed_pin;

	// longest bleed is the largest timeout field plus one step, plus a little slack
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			bleed_cnt_q <= 0;
		else if (o_sink_path_bleed_pin)
			bleed_cnt_q <= bleed_cnt_q + 1;
		else
			bleed_cnt_q <= 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	a_force_start: assert property (
		force_wr && !i_meas.is_source && i_meas.vbus_mv > 16'h0320 |=> o_vbus_discharge)
		else $error("forced discharge did not start");
	a_discharge_ends: assert property (
		o_vbus_discharge && i_meas.vbus_mv < 16'h0320 && !i_meas.is_source && !force_wr
		&& !i_meas.disconnect |=> !o_vbus_discharge)
		else $error("discharge kept on below safe level");
	a_no_restart: assert property (
		!o_vbus_discharge && !force_wr && !i_meas.disconnect |=> !o_vbus_discharge)
		else $error("discharge restarted without a trigger");
	a_bleed_cause: assert property (
		$rose(o_sink_path_bleed_pin) |-> $past(bleed_req))
		else $error("sink path bleed without a request");
	a_bleed_stops: assert property (
		o_sink_path_bleed_pin && i_meas.sink_path_mv < 16'h157c && !bleed_req
		|=> !o_sink_path_bleed_pin)
		else $error("bleed kept on below safe level");
	a_bleed_bounded: assert property (
		bleed_cnt_q <= 16 * STEP_CYCLES + 4)
		else $error("bleed outlasted its timeout");
	a_bleed_end_flag: assert property (
		$fell(o_sink_path_bleed_pin) |-> !o_alert_b || o_sink_gate)
		else $error("bleed ended without alert or gate");
	a_gate_cause: assert property (
		$rose(o_sink_gate) |-> $past(gate_req))
		else $error("sink gate on without command");
	a_swap_order: assert property (
		$rose(o_source_gate) |-> !o_sink_gate && !$past(o_sink_gate))
		else $error("source gate on before sink gate off");
	a_source_sticky: assert property (
		o_source_gate |=> o_source_gate)
		else $error("source gate dropped");
	a_unmapped_zero: assert property (
		i_req.rd && i_req.addr == 8'h02 |=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule

bind vbus_monitor_discharge_ctrl vbus_monitor_discharge_ctrl_checker #(
	.STEP_CYCLES(STEP_CYCLES)
) u_chk (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_meas(i_meas),
	.i_frs_signal(i_frs_signal), .o_rdata(o_rdata), .o_alert_b(o_alert_b),
	.o_vbus_discharge(o_vbus_discharge), .o_sink_path_bleed_pin(o_sink_path_bleed_pin),
	.o_sink_gate(o_sink_gate), .o_source_gate(o_source_gate));

/* port_manager_model.sv */
// port manager side: issues register requests and watches the alert pin
`timescale 1ns/1ps
module port_manager_model (
	input  wire logic                  i_clk,
	input  wire logic [15:0]           i_rdata,
	input  wire logic                  i_alert_b,
	output vbus_monitor_pkg::reg_req_t o_req
);
	initial o_req = '0;

	// released address and data show the inverse, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h5a5a};
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'ha5a5};
		#1;
		d = i_rdata;
	endtask

	task automatic clr(input logic [7:0] a, input logic [15:0] m);
		wr(a, m);
	endtask

	// the other port's sink enable waits on this alert
	task automatic await_alert(output logic seen);
		seen = 1'b0;
		for (int k = 0; k < 8 && !seen; k++)
		begin
			@(posedge i_clk);
			#1;
			seen = (i_alert_b === 1'b0);
		end
	endtask

	task automatic swap_msg(input logic [7:0] pcfg);
		wr(8'h1c, {8'h00, pcfg & 8'h7f});
	endtask
endmodule

/* vbus_monitor_discharge_ctrl_tb.sv */
// directed register-level tests of the vbus monitor and discharge block
`timescale 1ns/1ps
module vbus_monitor_discharge_ctrl_tb;
	localparam int STEP = 8;
	localparam logic [7:0]  RA [8] = '{8'h1c, 8'h76, 8'h78, 8'h90, 8'h98, 8'h9a, 8'h92, 8'h02};
	localparam logic [15:0] RV [8] = '{16'h0020, 16'hffff, 16'h0000, 16'h0000, 16'h0010,
		16'h0001, 16'h0000, 16'h0000};
	logic                       i_clk;
	logic                       i_rst_b;
	vbus_monitor_pkg::reg_req_t req;
	vbus_monitor_pkg::meas_t    meas;
	logic                       frs;
	logic [15:0]                rdata;
	logic                       alert_b;
	logic                       dis;
	logic                       bleed;
	logic                       gate;
	logic                       src;
	int                         n_errors = 0;
	int                         cmp_count = 0;

	vbus_monitor_discharge_ctrl #(.STEP_CYCLES(STEP)) DUT (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req), .i_meas(meas),
		.i_frs_signal(frs), .o_rdata(rdata), .o_alert_b(alert_b),
		.o_vbus_discharge(dis), .o_sink_path_bleed_pin(bleed),
		.o_sink_gate(gate), .o_source_gate(src));
	port_manager_model pm (.i_clk(i_clk), .i_rdata(rdata), .i_alert_b(alert_b), .o_req(req));

	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] v;
		pm.rd(a, v);
		chk(v & m, e);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic setv(input logic [15:0] v, input logic [15:0] p);
		@(posedge i_clk);
		meas.vbus_mv      <= v;
		meas.sink_path_mv <= p;
	endtask

	// k[0] disconnect, k[1] sink command, one cycle each
	task automatic pulse(input logic [1:0] k);
		@(posedge i_clk);
		meas.disconnect    <= k[0];
		meas.sink_vbus_cmd <= k[1];
		@(posedge i_clk);
		meas.disconnect    <= 1'b0;
		meas.sink_vbus_cmd <= 1'b0;
	endtask

	task automatic sample(input logic [15:0] x);
		@(posedge i_clk);
		meas.cur_sample <= x;
		meas.cur_valid  <= 1'b1;
		@(posedge i_clk);
		meas.cur_valid  <= 1'b0;
	endtask

	initial
	begin
		repeat (5000) @(posedge i_clk);
		n_errors++;
		wrap_up;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [15:0] xs [3];
		int          m;
		int          k;
		logic        ok;
		xs = '{16'h0064, 16'h0190, 16'h00c8};
		i_rst_b = 1'b0;
		meas = '0;
		frs = 1'b0;
		step(20);
		@(posedge i_clk);
		i_rst_b <= 1'b1;
		step(1);
		chk(alert_b, 1'b1);
		pm.wr(8'h92, 16'h1234);
		for (int i = 0; i < 8; i++)
			rchk(RA[i], 16'hffff, RV[i]);
		// alarms
		pm.wr(8'h76, 16'h1388);
		pm.wr(8'h78, 16'h0fa0);
		setv(16'h1770, 16'h0000);
		step(3);
		rchk(8'h10, 16'h0600, 16'h0000);
		pm.wr(8'h1c, 16'h0000);
		step(2);
		rchk(8'h10, 16'h0600, 16'h0200);
		chk(alert_b, 1'b0);
		pm.clr(8'h10, 16'h0200);
		rchk(8'h10, 16'h0600, 16'h0200);
		pm.wr(8'h10, 16'h0000);
		rchk(8'h10, 16'h0600, 16'h0200);
		setv(16'h0bb8, 16'h0000);
		pm.clr(8'h10, 16'h0200);
		step(2);
		rchk(8'h10, 16'h0600, 16'h0400);
		pm.wr(8'h1c, 16'h0020);
		pm.clr(8'h10, 16'h0400);
		rchk(8'h10, 16'h0600, 16'h0000);
		chk(alert_b, 1'b1);
		// current monitor: factor 2, exponent 1
		pm.wr(8'h90, 16'h00b2);
		m = 0;
		foreach (xs[i])
		begin
			sample(xs[i]);
			m = m + (((int'(xs[i]) - m) / 2) >>> 1);
		end
		step(2);
		rchk(8'h92, 16'hffff, 16'h00c8);
		rchk(8'h94, 16'hffff, 16'h0190);
		rchk(8'h96, 16'hffff, m[15:0]);
		pm.wr(8'h90, 16'h0001);
		sample(16'h03e7);
		step(2);
		rchk(8'h92, 16'hffff, 16'h00c8);
		rchk(8'h94, 16'hffff, 16'h0190);
		rchk(8'h96, 16'hffff, 16'h0000);
		// vbus discharge
		setv(16'h1388, 16'h0000);
		pm.wr(8'h1c, 16'h0024);
		step(1);
		chk(dis, 1'b1);
		setv(16'h01f4, 16'h0000);
		step(2);
		chk(dis, 1'b0);
		setv(16'h1388, 16'h0000);
		step(3);
		chk(dis, 1'b0);
		pm.wr(8'h1c, 16'h0030);
		pulse(2'b01);
		step(1);
		chk(dis, 1'b1);
		setv(16'h01f4, 16'h0000);
		step(2);
		chk(dis, 1'b0);
		pm.wr(8'h74, 16'h0bb8);
		setv(16'h1388, 16'h0000);
		meas.is_source <= 1'b1;
		pm.wr(8'h1c, 16'h0024);
		setv(16'h07d0, 16'h0000);
		step(2);
		chk(dis, 1'b0);
		// sink path, automatic mode
		pm.wr(8'h1c, 16'h0020);
		meas.is_source <= 1'b0;
		pm.wr(8'h9a, 16'h0031);
		setv(16'h1388, 16'h4e20);
		pulse(2'b10);
		step(2);
		chk({bleed, gate}, 2'b10);
		setv(16'h1388, 16'h0bb8);
		step(2);
		chk({bleed, gate}, 2'b01);
		setv(16'h1388, 16'h4e20);
		pulse(2'b01);
		step(2);
		chk({bleed, gate}, 2'b00);
		pm.wr(8'h9a, 16'h0011);
		pulse(2'b10);
		step(2);
		chk(bleed, 1'b1);
		step(24);
		chk({bleed, gate, alert_b}, 3'b000);
		rchk(8'ha0, 16'hc000, 16'hc000);
		pm.clr(8'ha0, 16'hc000);
		// sink path, manual mode
		pm.wr(8'h9a, 16'h0010);
		pm.wr(8'h9a, 16'h0012);
		step(1);
		chk(bleed, 1'b1);
		setv(16'h1388, 16'h0bb8);
		pm.await_alert(ok);
		chk({ok, bleed}, 2'b10);
		rchk(8'ha0, 16'hc000, 16'h4000);
		pm.clr(8'ha0, 16'hc000);
		setv(16'h1388, 16'h4e20);
		pm.wr(8'h9a, 16'h0012);
		step(24);
		chk({bleed, alert_b}, 2'b00);
		rchk(8'ha0, 16'hc000, 16'hc000);
		pm.clr(8'ha0, 16'hc000);
		// role swap: refused while disabled, then ordered gates
		pm.wr(8'h9a, 16'h0001);
		setv(16'h1388, 16'h0bb8);
		pulse(2'b10);
		pm.wr(8'h98, 16'h0013);
		frs <= 1'b1;
		step(8);
		chk({gate, src}, 2'b10);
		@(posedge i_clk);
		frs <= 1'b0;
		pm.wr(8'h1c, 16'h00a0);
		frs <= 1'b1;
		k = 0;
		while (gate !== 1'b0 && k < 10)
		begin
			step(1);
			k++;
		end
		chk({gate, src}, 2'b00);
		step(8);
		chk({gate, src}, 2'b01);
		pm.swap_msg(8'ha0);
		frs <= 1'b0;
		wrap_up;
	end
endmodule
